// file: core/pwsi_event_latch.sv
// Sticky event bits: a set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module pwsi_event_latch
    import pwsi_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    output logic      [WIDTH-1:0] q
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= (q & ~clr_in) | set_in;
        end
    end

endmodule

`default_nettype wire

// file: core/pwsi_pkg.sv
// Types shared by the watchdog status and interrupt block
`default_nettype none
package pwsi_pkg;

    typedef logic [7:0] pwsi_byte_type;

    typedef enum logic [1:0] {
        PWSI_THR_OFF,
        PWSI_THR_ONE,
        PWSI_THR_TWO,
        PWSI_THR_FOUR
    } pwsi_thr_type;

endpackage
`default_nettype wire

// file: core/pwsi_regs.svh
// Register indices, field positions and reset values of the watchdog status and interrupt block
`ifndef PWSI_REGS_SVH
`define PWSI_REGS_SVH

// Register indices; the byte address is four times the index
`define PWSI_IDX_WD_CONFIG      6'h1c
`define PWSI_IDX_WD_MODE        6'h1d
`define PWSI_IDX_WATCHDOG_STATUS      6'h1e
`define PWSI_IDX_SOFT_RESET     6'h1f
`define PWSI_IDX_TOP_INT        6'h20
`define PWSI_IDX_TOP_INT_2      6'h21
`define PWSI_IDX_LIVE_STATUS    6'h30

// Watchdog config / mode fields
`define PWSI_THR_SEL_LSB        0
`define PWSI_FLAG_MODE_BIT      4

// Watchdog status fields
`define PWSI_FLAG_CLR_BIT       4
`define PWSI_FLAG_BIT           3
`define PWSI_CNT_CLR_BIT        2
`define PWSI_CNT_LSB            0

// Software reset fields
`define PWSI_SOFT_RST_BIT       0

// Top interrupt fields
`define PWSI_TOP_LOAD_MEAS_BIT  7
`define PWSI_TOP_DIAG_BIT       6
`define PWSI_TOP_BOOST_BIT      5
`define PWSI_TOP_BUCK_BIT       4
`define PWSI_TOP_SYNC_BIT       3
`define PWSI_TOP_TSD_BIT        2
`define PWSI_TOP_WARN_BIT       1
`define PWSI_TOP_OVP_BIT        0

// Second top interrupt fields
`define PWSI_TOP2_RESET_BIT     0

// Live status fields
`define PWSI_LIVE_OVP_BIT       0
`define PWSI_LIVE_WARN_BIT      1
`define PWSI_LIVE_TSD_BIT       2

// Reset values
`define PWSI_RST_THR_SEL        2'h0
`define PWSI_RST_FLAG_MODE      1'h0
`define PWSI_RST_BYTE           8'h00
`define PWSI_RST_CNT            3'h0

`endif

// file: core/pwsi_top.sv
// Watchdog status, software reset and top interrupt registers behind an APB slave
`timescale 1ns/1ps
`default_nettype none

`include "pwsi_regs.svh"

module pwsi_top
    import pwsi_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  watchdog_reset_output,
    input  wire logic                  load_meas_ready,
    input  wire logic                  diag_sub_interrupts_pending,
    input  wire logic                  boost_sub_pending,
    input  wire logic                  buck_sub_pending,
    input  wire logic                  sync_clk_valid,
    input  wire logic                  thermal_shutdown_level,
    input  wire logic                  thermal_warning_level,
    input  wire logic                  overvoltage_level,
    output logic                       irq,
    output logic                       system_restart_req,
    output logic                       otp_reload_req,
    output logic                       conv_disable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    localparam logic [ADDR_WIDTH-1:0] ADDR_WD_CONFIG   = {`PWSI_IDX_WD_CONFIG, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] ADDR_WD_MODE     = {`PWSI_IDX_WD_MODE, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] ADDR_WATCHDOG_STATUS   = {`PWSI_IDX_WATCHDOG_STATUS, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] ADDR_SOFT_RESET  = {`PWSI_IDX_SOFT_RESET, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] ADDR_TOP_INT     = {`PWSI_IDX_TOP_INT, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] ADDR_TOP_INT_2   = {`PWSI_IDX_TOP_INT_2, 2'h0};
    localparam logic [ADDR_WIDTH-1:0] ADDR_LIVE_STATUS = {`PWSI_IDX_LIVE_STATUS, 2'h0};

    wire logic setup_phase;
    wire logic access_done;
    wire logic write_done;
    wire logic hit_cfg;
    wire logic hit_mode;
    wire logic hit_wds;
    wire logic hit_srst;
    wire logic hit_top;
    wire logic hit_top2;
    wire logic hit_live;
    wire logic addr_mapped;

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign write_done  = access_done & pwrite;
    assign hit_cfg     = (paddr == ADDR_WD_CONFIG);
    assign hit_mode    = (paddr == ADDR_WD_MODE);
    assign hit_wds     = (paddr == ADDR_WATCHDOG_STATUS);
    assign hit_srst    = (paddr == ADDR_SOFT_RESET);
    assign hit_top     = (paddr == ADDR_TOP_INT);
    assign hit_top2    = (paddr == ADDR_TOP_INT_2);
    assign hit_live    = (paddr == ADDR_LIVE_STATUS);
    assign addr_mapped = hit_cfg | hit_mode | hit_wds | hit_srst | hit_top | hit_top2 | hit_live;

    wire logic wr_cfg;
    wire logic wr_mode;
    wire logic wr_wds;
    wire logic wr_srst;
    wire logic wr_top;
    wire logic wr_top2;

    assign wr_cfg  = write_done & hit_cfg;
    assign wr_mode = write_done & hit_mode;
    assign wr_wds  = write_done & hit_wds;
    assign wr_srst = write_done & hit_srst;
    assign wr_top  = write_done & hit_top;
    assign wr_top2 = write_done & hit_top2;

    ////////////////////////////////////////////////////////////////////////////////
    // Software reset

    logic soft_rst_pend_r;
    logic otp_reload_r;
    wire logic soft_act;

    // Pending bit reads one for a single cycle, then the reset acts and it drops
    assign soft_act = soft_rst_pend_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_rst_pend_r <= 1'b0;
            otp_reload_r    <= 1'b0;
        end else begin
            soft_rst_pend_r <= wr_srst & pwdata[`PWSI_SOFT_RST_BIT] & ~soft_act;
            otp_reload_r    <= soft_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog configuration

    pwsi_thr_type thr_sel_r;
    logic         flag_mode_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_sel_r   <= pwsi_thr_type'(`PWSI_RST_THR_SEL);
            flag_mode_r <= `PWSI_RST_FLAG_MODE;
        end else if (soft_act) begin
            thr_sel_r   <= pwsi_thr_type'(`PWSI_RST_THR_SEL);
            flag_mode_r <= `PWSI_RST_FLAG_MODE;
        end else begin
            if (wr_cfg) begin
                thr_sel_r <= pwsi_thr_type'(pwdata[`PWSI_THR_SEL_LSB +: 2]);
            end
            if (wr_mode) begin
                flag_mode_r <= pwdata[`PWSI_FLAG_MODE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog reset-pulse counter and restart flag

    logic       cnt_clr_r;
    logic       flag_clr_pend_r;
    logic       flag_r;
    logic [2:0] cnt_r;
    logic       restart_r;

    logic [2:0] thr_count;
    wire  logic [2:0] cnt_base;
    wire  logic [2:0] cnt_inc;
    wire  logic       thr_reached;
    wire  logic       restart_blocked;
    wire  logic       restart_fire;
    logic [2:0] cnt_nxt;

    always_comb begin
        unique case (thr_sel_r)
            PWSI_THR_OFF:  thr_count = 3'h0;
            PWSI_THR_ONE:  thr_count = 3'h1;
            PWSI_THR_TWO:  thr_count = 3'h2;
            PWSI_THR_FOUR: thr_count = 3'h4;
        endcase
    end

    assign cnt_base        = cnt_clr_r ? `PWSI_RST_CNT : cnt_r;
    assign cnt_inc         = cnt_base + 3'h1;
    assign thr_reached     = watchdog_reset_output & (thr_count != 3'h0) & (cnt_inc >= thr_count);
    assign restart_blocked = flag_mode_r & flag_r;
    assign restart_fire    = thr_reached & ~restart_blocked;

    always_comb begin
        cnt_nxt = cnt_base;
        if (soft_act) begin
            cnt_nxt = `PWSI_RST_CNT;
        end else if (restart_fire) begin
            cnt_nxt = `PWSI_RST_CNT;
        end else if (thr_reached) begin
            cnt_nxt = thr_count;
        end else if (watchdog_reset_output) begin
            cnt_nxt = cnt_inc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_clr_r       <= 1'b0;
            flag_clr_pend_r <= 1'b0;
            flag_r          <= 1'b0;
            cnt_r           <= `PWSI_RST_CNT;
            restart_r       <= 1'b0;
        end else begin
            cnt_clr_r       <= wr_wds & pwdata[`PWSI_CNT_CLR_BIT];
            flag_clr_pend_r <= wr_wds & pwdata[`PWSI_FLAG_CLR_BIT] & ~flag_clr_pend_r;
            flag_r          <= restart_fire | (flag_r & ~(flag_clr_pend_r | soft_act));
            cnt_r           <= cnt_nxt;
            restart_r       <= restart_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Top interrupt events

    logic       sync_valid_d_r;
    logic [2:0] summary_r;
    logic       warn_stat_r;
    logic       irq_r;
    logic       conv_dis_r;

    wire logic       sync_change;
    wire logic [4:0] ev_set;
    wire logic [4:0] ev_clr;
    wire logic [4:0] ev_q;
    wire logic       tsd_clear;
    wire logic       rst_ev_q;
    pwsi_byte_type   top_byte;

    assign sync_change = sync_clk_valid ^ sync_valid_d_r;

    // Latched bits packed as load, sync, shutdown, warning, overvoltage
    assign ev_set = {load_meas_ready,
                     sync_change,
                     thermal_shutdown_level,
                     thermal_warning_level,
                     overvoltage_level};

    assign ev_clr = {5{soft_act}} | ({5{wr_top}} & {pwdata[`PWSI_TOP_LOAD_MEAS_BIT],
                                                     pwdata[`PWSI_TOP_SYNC_BIT],
                                                     pwdata[`PWSI_TOP_TSD_BIT],
                                                     pwdata[`PWSI_TOP_WARN_BIT],
                                                     pwdata[`PWSI_TOP_OVP_BIT]});

    pwsi_event_latch #(
        .WIDTH (5)
    ) u_top_events (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (ev_set),
        .clr_in  (ev_clr),
        .q       (ev_q)
    );

    pwsi_event_latch #(
        .WIDTH (1)
    ) u_reset_event (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (soft_act),
        .clr_in  (wr_top2 & pwdata[`PWSI_TOP2_RESET_BIT]),
        .q       (rst_ev_q)
    );

    assign tsd_clear = wr_top & pwdata[`PWSI_TOP_TSD_BIT];

    always_comb begin
        top_byte                          = `PWSI_RST_BYTE;
        top_byte[`PWSI_TOP_LOAD_MEAS_BIT] = ev_q[4];
        top_byte[`PWSI_TOP_DIAG_BIT]      = summary_r[2];
        top_byte[`PWSI_TOP_BOOST_BIT]     = summary_r[1];
        top_byte[`PWSI_TOP_BUCK_BIT]      = summary_r[0];
        top_byte[`PWSI_TOP_SYNC_BIT]      = ev_q[3];
        top_byte[`PWSI_TOP_TSD_BIT]       = ev_q[2];
        top_byte[`PWSI_TOP_WARN_BIT]      = ev_q[1];
        top_byte[`PWSI_TOP_OVP_BIT]       = ev_q[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_valid_d_r <= 1'b0;
            summary_r      <= 3'h0;
            warn_stat_r    <= 1'b0;
            irq_r          <= 1'b0;
            conv_dis_r     <= 1'b0;
        end else begin
            sync_valid_d_r <= sync_clk_valid;
            // Summary bits follow the sub-registers; no write reaches them
            summary_r      <= {diag_sub_interrupts_pending,
                               boost_sub_pending,
                               buck_sub_pending};
            // Warning status holds until the shutdown event is cleared
            warn_stat_r    <= thermal_warning_level
                            | (warn_stat_r & ~(tsd_clear | soft_act));
            irq_r          <= |top_byte;
            conv_dis_r     <= ev_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and APB response

    pwsi_byte_type rd_cfg;
    pwsi_byte_type rd_mode;
    pwsi_byte_type rd_wds;
    pwsi_byte_type rd_srst;
    pwsi_byte_type rd_top2;
    pwsi_byte_type rd_live;
    pwsi_byte_type rd_byte;

    always_comb begin
        rd_cfg                              = `PWSI_RST_BYTE;
        rd_cfg[`PWSI_THR_SEL_LSB +: 2]      = thr_sel_r;
        rd_mode                             = `PWSI_RST_BYTE;
        rd_mode[`PWSI_FLAG_MODE_BIT]        = flag_mode_r;
        rd_wds                              = `PWSI_RST_BYTE;
        rd_wds[`PWSI_FLAG_CLR_BIT]          = flag_clr_pend_r;
        rd_wds[`PWSI_FLAG_BIT]              = flag_r;
        rd_wds[`PWSI_CNT_CLR_BIT]           = cnt_clr_r;
        rd_wds[`PWSI_CNT_LSB +: 2]          = cnt_r[1:0];
        rd_srst                             = `PWSI_RST_BYTE;
        rd_srst[`PWSI_SOFT_RST_BIT]         = soft_rst_pend_r;
        rd_top2                             = `PWSI_RST_BYTE;
        rd_top2[`PWSI_TOP2_RESET_BIT]       = rst_ev_q;
        rd_live                             = `PWSI_RST_BYTE;
        rd_live[`PWSI_LIVE_OVP_BIT]         = overvoltage_level;
        rd_live[`PWSI_LIVE_WARN_BIT]        = warn_stat_r;
        rd_live[`PWSI_LIVE_TSD_BIT]         = thermal_shutdown_level;
    end

    assign rd_byte = ({8{hit_cfg}}  & rd_cfg)
                   | ({8{hit_mode}} & rd_mode)
                   | ({8{hit_wds}}  & rd_wds)
                   | ({8{hit_srst}} & rd_srst)
                   | ({8{hit_top}}  & top_byte)
                   | ({8{hit_top2}} & rd_top2)
                   | ({8{hit_live}} & rd_live);

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    // One access cycle: ready rises the cycle after setup, data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup_phase;
            pslverr_r <= setup_phase & ~addr_mapped;
            prdata_r  <= (setup_phase & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign irq                = irq_r;
    assign system_restart_req = restart_r;
    assign otp_reload_req     = otp_reload_r;
    assign conv_disable       = conv_dis_r;

endmodule

`default_nettype wire

// file: verif/pwsi_far_model.sv
// Far-side model: watchdog pulse source and the three sub-interrupt registers
`timescale 1ns/1ps
`default_nettype none

module pwsi_far_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] sub_set,
    input  wire logic [2:0] sub_clr,
    input  wire logic [2:0] pulse_cnt,
    input  wire logic       pulse_go,
    output logic            watchdog_reset_output,
    output logic            diag_sub_interrupts_pending,
    output logic            boost_sub_pending,
    output logic            buck_sub_pending
);
    logic [7:0] sub_r [3];
    logic [2:0] left_r;
    logic       gap_r;

    // Pending means the sub-register is not 0x00
    assign diag_sub_interrupts_pending = |sub_r[0];
    assign boost_sub_pending           = |sub_r[1];
    assign buck_sub_pending            = |sub_r[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                sub_r[i] <= 8'h00;
            end
            left_r <= 3'h0;
            gap_r <= 1'b0;
            watchdog_reset_output <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (sub_clr[i]) begin
                    sub_r[i] <= 8'h00;
                end else if (sub_set[i]) begin
                    sub_r[i] <= sub_r[i] | 8'h01;
                end
            end
            // One-cycle pulses with a gap, so each one is counted
            watchdog_reset_output <= (left_r != 3'h0) && !gap_r;
            gap_r <= (left_r != 3'h0) && !gap_r;
            if (pulse_go) begin
                left_r <= pulse_cnt;
            end else if ((left_r != 3'h0) && !gap_r) begin
                left_r <= left_r - 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/pwsi_top_monitor.sv
// Port-level assertions of the watchdog status and interrupt block
`timescale 1ns/1ps
`default_nettype none

module pwsi_top_monitor #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  watchdog_reset_output,
    input wire logic                  load_meas_ready,
    input wire logic                  diag_sub_interrupts_pending,
    input wire logic                  boost_sub_pending,
    input wire logic                  buck_sub_pending,
    input wire logic                  thermal_shutdown_level,
    input wire logic                  irq,
    input wire logic                  system_restart_req,
    input wire logic                  otp_reload_req,
    input wire logic                  conv_disable
);
    wire logic mapped;
    assign mapped = paddr inside {8'h70, 8'h74, 8'h78, 8'h7c, 8'h80, 8'h84, 8'hc0};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_soft_wr;
        psel && penable && pready && pwrite && (paddr == 8'h7c) && pwdata[0];
    endsequence
    sequence s_pending;
        diag_sub_interrupts_pending || boost_sub_pending || buck_sub_pending;
    endsequence

    a_setup_ready: assert property (s_setup |=> pready)
        else $error("setup not answered in the next cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr && pready)
        else $error("unmapped address not refused");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside access");
    a_meas_irq: assert property (load_meas_ready |-> ##2 irq)
        else $error("measurement event did not raise irq");
    a_pending_irq: assert property (s_pending |-> ##2 irq)
        else $error("sub-register pending did not raise irq");
    a_tsd_disable: assert property (thermal_shutdown_level |-> ##2 conv_disable)
        else $error("thermal shutdown did not disable converters");
    a_restart_cause: assert property (system_restart_req |-> $past(watchdog_reset_output))
        else $error("restart without a watchdog pulse");
    a_restart_pulse: assert property (system_restart_req |=> !system_restart_req)
        else $error("restart request longer than one cycle");
    a_soft_reload: assert property (s_soft_wr |-> ##[1:3] otp_reload_req)
        else $error("soft reset did not request a reload");
endmodule

bind pwsi_top pwsi_top_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_reset_output(watchdog_reset_output), .load_meas_ready(load_meas_ready),
    .diag_sub_interrupts_pending(diag_sub_interrupts_pending),
    .boost_sub_pending(boost_sub_pending), .buck_sub_pending(buck_sub_pending),
    .thermal_shutdown_level(thermal_shutdown_level), .irq(irq),
    .system_restart_req(system_restart_req), .otp_reload_req(otp_reload_req),
    .conv_disable(conv_disable)
);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the watchdog status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "pwsi_regs.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module testbench;
    localparam logic [7:0] A_CFG  = {`PWSI_IDX_WD_CONFIG, 2'b00};
    localparam logic [7:0] A_MODE = {`PWSI_IDX_WD_MODE, 2'b00};
    localparam logic [7:0] A_WDS  = {`PWSI_IDX_WATCHDOG_STATUS, 2'b00};
    localparam logic [7:0] A_SRST = {`PWSI_IDX_SOFT_RESET, 2'b00};
    localparam logic [7:0] A_TOP  = {`PWSI_IDX_TOP_INT, 2'b00};
    localparam logic [7:0] A_TOP2 = {`PWSI_IDX_TOP_INT_2, 2'b00};
    localparam logic [7:0] A_LIVE = {`PWSI_IDX_LIVE_STATUS, 2'b00};

    logic        pclk, presetn, psel, penable, pwrite, pulse_go;
    logic [7:0]  paddr, m, s, t;
    logic [7:0]  rst_cnt = 8'h00;
    logic [7:0]  otp_cnt = 8'h00;
    logic [31:0] pwdata, prdata, rv;
    logic [31:0] seed = 32'h00000006;
    logic        pready, pslverr, irq, system_restart_req, otp_reload_req, conv_disable;
    logic        watchdog_reset_output, diag_p, boost_p, buck_p, load_meas_ready;
    logic        sync_clk_valid, thermal_shutdown_level, thermal_warning_level;
    logic        overvoltage_level;
    logic [2:0]  sub_set, sub_clr, pulse_cnt;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int          error_cnt, total_checks;
    int          evb[6] = '{0, 1, 2, 3, 3, 7};

    pwsi_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdog_reset_output(watchdog_reset_output), .load_meas_ready(load_meas_ready),
        .diag_sub_interrupts_pending(diag_p), .boost_sub_pending(boost_p),
        .buck_sub_pending(buck_p), .sync_clk_valid(sync_clk_valid),
        .thermal_shutdown_level(thermal_shutdown_level),
        .thermal_warning_level(thermal_warning_level), .overvoltage_level(overvoltage_level),
        .irq(irq), .system_restart_req(system_restart_req), .otp_reload_req(otp_reload_req),
        .conv_disable(conv_disable)
    );
    pwsi_far_model far (
        .pclk(pclk), .presetn(presetn), .sub_set(sub_set), .sub_clr(sub_clr),
        .pulse_cnt(pulse_cnt), .pulse_go(pulse_go), .watchdog_reset_output(watchdog_reset_output),
        .diag_sub_interrupts_pending(diag_p), .boost_sub_pending(boost_p),
        .buck_sub_pending(buck_p)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    ////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic err, input logic [7:0] exp);
        exp_q.push_back({~wr, err, 24'h000000, exp});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= (xs() & 32'hffffff00) | {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 1'b0, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0, 8'h00);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic ev(input int b);
        @(posedge pclk);
        case (b)
            0: overvoltage_level <= 1'b1;
            1: thermal_warning_level <= 1'b1;
            2: thermal_shutdown_level <= 1'b1;
            3: sync_clk_valid <= ~sync_clk_valid;
            default: load_meas_ready <= 1'b1;
        endcase
        @(posedge pclk);
        overvoltage_level <= 1'b0;
        thermal_warning_level <= 1'b0;
        thermal_shutdown_level <= 1'b0;
        load_meas_ready <= 1'b0;
        cyc(3);
    endtask

    task automatic pulses(input logic [2:0] n);
        @(posedge pclk);
        pulse_cnt <= n;
        pulse_go <= 1'b1;
        @(posedge pclk);
        pulse_go <= 1'b0;
        cyc(2 * n + 3);
    endtask

    task summarize();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Scoreboard: every answered transfer takes the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(pslverr, e[32])
            if (e[33]) `CHK(prdata, e[31:0])
        end
        if (system_restart_req === 1'b1) rst_cnt <= rst_cnt + 8'h01;
        if (otp_reload_req === 1'b1) otp_cnt <= otp_cnt + 8'h01;
    end

    initial begin
        #1000000;
        error_cnt++;
        summarize();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, pulse_go, load_meas_ready, sync_clk_valid} = '0;
        {thermal_shutdown_level, thermal_warning_level, overvoltage_level} = '0;
        {paddr, pwdata, sub_set, sub_clr, pulse_cnt} = '0;
        cyc(2);
        presetn <= 1'b1;
        rd(A_WDS, 8'h00);
        rd(A_SRST, 8'h00);
        rd(A_TOP, 8'h00);
        apb(1'b0, 8'h90, 8'h00, 1'b1, 8'h00);
        apb(1'b1, 8'h79, 8'hff, 1'b1, 8'h00);
        foreach (evb[i]) begin
            m = 8'h01 << evb[i];
            ev(evb[i]);
            rd(A_TOP, m);
            `CHK(irq, 1'b1)
            if (evb[i] == 2) `CHK(conv_disable, 1'b1)
            rd(A_LIVE, (evb[i] == 1) ? 8'h02 : 8'h00);
            rv = xs();
            wr(A_TOP, rv[7:0] & ~m & 8'hfb);
            rd(A_TOP, m);
            wr(A_TOP, m | 8'h04);
            rd(A_TOP, 8'h00);
            rd(A_LIVE, 8'h00);
            `CHK(irq, 1'b0)
            `CHK(conv_disable, 1'b0)
        end
        for (int i = 0; i < 3; i++) begin
            m = 8'h40 >> i;
            @(posedge pclk) sub_set <= 3'b001 << i;
            @(posedge pclk) sub_set <= 3'b000;
            cyc(3);
            rd(A_TOP, m);
            wr(A_TOP, m);
            rd(A_TOP, m);
            @(posedge pclk) sub_clr <= 3'b001 << i;
            @(posedge pclk) sub_clr <= 3'b000;
            cyc(3);
            rd(A_TOP, 8'h00);
        end
        for (s = 8'h01; s < 8'h04; s++) begin
            t = (s == 8'h03) ? 8'h04 : s;
            wr(A_CFG, s);
            pulses(t[2:0] - 3'h1);
            rd(A_WDS, t - 8'h01);
            pulses(3'h1);
            rd(A_WDS, 8'h08);
            `CHK(rst_cnt, s)
            wr(A_WDS, 8'h10);
            rd(A_WDS, 8'h00);
        end
        wr(A_CFG, 8'h00);
        pulses(3'h5);
        rd(A_WDS, 8'h01);
        `CHK(rst_cnt, 8'h03)
        wr(A_WDS, 8'h04);
        rd(A_WDS, 8'h00);
        wr(A_MODE, 8'h10);
        rd(A_MODE, 8'h10);
        wr(A_CFG, 8'h01);
        pulses(3'h1);
        rd(A_WDS, 8'h08);
        pulses(3'h1);
        rd(A_WDS, 8'h09);
        `CHK(rst_cnt, 8'h04)
        wr(A_WDS, 8'h14);
        rd(A_WDS, 8'h00);
        ev(7);
        wr(A_SRST, 8'h01);
        cyc(3);
        `CHK(otp_cnt, 8'h01)
        rd(A_SRST, 8'h00);
        rd(A_CFG, 8'h00);
        rd(A_MODE, 8'h00);
        rd(A_TOP, 8'h00);
        rd(A_TOP2, 8'h01);
        wr(A_TOP2, 8'h01);
        rd(A_TOP2, 8'h00);
        cyc(2);
        summarize();
    end
endmodule
`default_nettype wire
